/* inc/wdg_consts.svh */
// Named constants for the watchdog downcounter: offsets, fields, reset values and timing.
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// Byte offsets of the APB registers.
`define WDG_OFS_STATUS 12'h000
`define WDG_OFS_UPPER 12'h004
`define WDG_OFS_HIGH 12'h008
`define WDG_OFS_LOW 12'h00c
`define WDG_OFS_OPTION 12'h010
`define WDG_OFS_COUNT 12'h014

// Field positions in the reset cause register.
`define WDG_ST_TIMEOUT 0
`define WDG_ST_STOP 1
`define WDG_ST_RESET 2
`define WDG_ST_RUNNING 3

// Field positions in the option register.
`define WDG_OPT_ALWAYS_ON 0
`define WDG_OPT_RESPONSE 1

// Reset values of the reload bytes.
`define WDG_RST_UPPER 8'h00
`define WDG_RST_HIGH 8'h04
`define WDG_RST_LOW 8'h00

// Counter values with special meaning.
`define WDG_CNT_ZERO 24'h000000
`define WDG_CNT_ONE 24'h000001
`define WDG_CNT_LAST_REFRESH 24'h000002
`define WDG_CNT_MAX 24'hffffff

// Timing: system clock rate and nominal watchdog oscillator rate, both in hertz.
`define WDG_PCLK_HZ 10000000
`define WDG_OSC_HZ 10000
// System clocks per watchdog oscillator period, rounded down, never below one.
`define WDG_TICK_CYCLES ((`WDG_PCLK_HZ / `WDG_OSC_HZ) < 1 ? 1 : (`WDG_PCLK_HZ / `WDG_OSC_HZ))

`endif

/* inc/wdg_pkg.sv */
// Types shared by the watchdog downcounter and its users.
`default_nettype none
package wdg_pkg;

  // Requests that the processor core and debug logic present to the watchdog.
  typedef struct packed {
    logic refresh;     // One-cycle pulse: the refresh instruction executed.
    logic debug_mode;  // Level: the on-chip debugger holds the device.
    logic stop_mode;   // Level: the device sits in STOP mode.
  } wdg_core_in_t;

  // Indications that the watchdog presents to the system.
  typedef struct packed {
    logic irq;            // Level: interrupt request to the interrupt controller.
    logic sys_reset;      // Level: system reset request.
    logic stop_recovery;  // One-cycle pulse: start a stop mode recovery.
  } wdg_core_out_t;

endpackage
`default_nettype wire

/* rtl/wdg_downcounter.sv */
// Watchdog downcounter with APB register access, refresh, timeout response and status flags.
//
// Behaviour
// - Count on own oscillator tick; timeout resets or interrupts.
// - Only off and on; never stops once on.
// - Enabled by refresh or always-on option bit.
// - 24-bit counter, reload is upper-high-low bytes.
// - Timeout in ms equals reload divided by ten.
// - Refresh ignored once counter reaches two.
// - First enable loads reload value before counting.
// - Each refresh reloads counter, counting then continues.
// - Debug mode refreshes counter continuously, no timeout.
// - Timeout at zero; option selects reset or interrupt.
// - Interrupt timeout raises request and sets status.
// - After interrupt timeout, counter wraps to maximum.
// - Status read clears timeout flag, stops interrupts.
// - Interrupt timeout in STOP starts recovery and interrupts.
// - Interrupt timeout in STOP sets timeout and stop bits.
// - Interrupt stays asserted while timeout condition lasts.
// - Reload bytes reset to 00, 04, 00.
// - Control writes share the status read address.
`include "wdg_consts.svh"
`default_nettype none

module wdg_downcounter
  import wdg_pkg::*;
#(
  parameter int TICK_CYCLES = `WDG_TICK_CYCLES,  // System clocks per watchdog oscillator period.
  parameter bit ALWAYS_ON_DEFAULT = 1'b0,        // Reset value of the always-on option bit.
  parameter bit RESPONSE_DEFAULT = 1'b0          // Reset value of the response bit: 1 selects reset.
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdg_core_in_t core_in,
  output wdg_core_out_t core_out
);

  // The divider needs at least one cycle per tick.
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;  // Divider width.
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);        // Last divider count.

  // Counter lifecycle: off until first enabled, then on for good.
  typedef enum logic {
    WDG_OFF = 1'b0,
    WDG_ON = 1'b1
  } wdg_state_t;

  wdg_state_t state;            // Off or on.
  logic [TW-1:0] div_cnt;       // Oscillator period divider.
  logic [23:0] count;           // The downcounter itself.
  logic [7:0] reload_upper_byte;  // Most significant reload byte.
  logic [7:0] reload_high_byte;   // Middle reload byte.
  logic [7:0] reload_low_byte;    // Least significant reload byte.
  logic always_on_option;         // Enables the counter right after reset.
  logic timeout_response_option;  // 0 selects interrupt, 1 selects reset.
  logic timeout_flag;             // Sticky watchdog timeout status.
  logic stop_flag;                // Sticky stop recovery status.
  logic reset_flag;               // Sticky watchdog reset cause.

  // Bus decode wires.
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_status = (paddr == `WDG_OFS_STATUS);
  wire hit_upper = (paddr == `WDG_OFS_UPPER);
  wire hit_high = (paddr == `WDG_OFS_HIGH);
  wire hit_low = (paddr == `WDG_OFS_LOW);
  wire hit_option = (paddr == `WDG_OFS_OPTION);
  wire hit_count = (paddr == `WDG_OFS_COUNT);
  wire mapped = hit_status || hit_upper || hit_high || hit_low || hit_option || hit_count;
  wire wr_ok = access && pwrite && mapped && pstrb[0];
  // A write to the status address reaches the control port instead.
  wire wr_control = wr_ok && hit_status;
  wire rd_status = access && !pwrite && hit_status;

  // Watchdog timing and counter control wires.
  wire [23:0] reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};
  wire running = (state == WDG_ON);
  // One tick per oscillator period; every decrement is taken on exactly one tick.
  wire tick = (div_cnt == TICK_LAST);
  // Refresh comes from the instruction or from a control write.
  wire refresh_req = core_in.refresh || wr_control;
  wire enable_req = refresh_req || always_on_option;
  wire refresh_allowed = (count > `WDG_CNT_LAST_REFRESH);
  wire at_zero = running && (count == `WDG_CNT_ZERO);
  // The timeout is the step from one to zero, unless the debugger holds the counter.
  wire timeout_evt = running && tick && (count == `WDG_CNT_ONE) && !core_in.debug_mode;
  wire irq_mode = !timeout_response_option;
  wire stop_evt = timeout_evt && irq_mode && core_in.stop_mode;

  // Read data selection; reserved bits read as zero.
  wire [31:0] status_word = {28'h0000000, running, reset_flag, stop_flag, timeout_flag};
  wire [31:0] rd_mux =
    hit_status ? status_word :
    hit_upper ? {24'h000000, reload_upper_byte} :
    hit_high ? {24'h000000, reload_high_byte} :
    hit_low ? {24'h000000, reload_low_byte} :
    hit_option ? {30'h00000000, timeout_response_option, always_on_option} :
    hit_count ? {8'h00, count} : 32'h00000000;

  // Next values of the indications, registered below.
  wire next_irq = at_zero && irq_mode && timeout_flag;
  wire next_sys_reset = at_zero && timeout_response_option;

  // Every transfer completes in one access cycle; unmapped addresses report an error.
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup && !pwrite)
    begin
      prdata <= rd_mux;
    end
  end

  // Reload bytes and option bits, written over the bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reload_upper_byte <= `WDG_RST_UPPER;
      reload_high_byte <= `WDG_RST_HIGH;
      reload_low_byte <= `WDG_RST_LOW;
      always_on_option <= ALWAYS_ON_DEFAULT;
      timeout_response_option <= RESPONSE_DEFAULT;
    end
    else if (wr_ok)
    begin
      // Only the addressed register changes.
      if (hit_upper)
      begin
        reload_upper_byte <= pwdata[7:0];
      end
      if (hit_high)
      begin
        reload_high_byte <= pwdata[7:0];
      end
      if (hit_low)
      begin
        reload_low_byte <= pwdata[7:0];
      end
      if (hit_option)
      begin
        always_on_option <= pwdata[`WDG_OPT_ALWAYS_ON];
        timeout_response_option <= pwdata[`WDG_OPT_RESPONSE];
      end
    end
  end

  // Oscillator divider: free running, one tick per nominal 10 kHz period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= '0;
    end
    else if (tick)
    begin
      div_cnt <= '0;
    end
    else
    begin
      div_cnt <= div_cnt + TW'(1);
    end
  end

  // Lifecycle: once on, the counter never returns to off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= WDG_OFF;
    end
    else
    begin
      case (state)
        WDG_OFF:
        begin
          // Leave off on the first enable request.
          if (enable_req)
          begin
            state <= WDG_ON;
          end
        end
        WDG_ON:
        begin
          // No path leads back to off.
          state <= WDG_ON;
        end
        default:
        begin
          state <= WDG_OFF;
        end
      endcase
    end
  end

  // The downcounter: load, refresh, debug hold, decrement and wrap.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= `WDG_CNT_ZERO;
    end
    else if (!running)
    begin
      // The first enable loads the reload value.
      if (enable_req)
      begin
        count <= reload_value;
      end
    end
    else if (core_in.debug_mode)
    begin
      // The debugger keeps the counter refreshed every cycle.
      count <= reload_value;
    end
    else if (refresh_req && refresh_allowed)
    begin
      // A refresh reloads; counting continues from there.
      count <= reload_value;
    end
    else if (tick)
    begin
      if (count == `WDG_CNT_ZERO)
      begin
        // After a timeout the counter wraps rather than reloading.
        count <= `WDG_CNT_MAX;
      end
      else
      begin
        count <= count - 24'h000001;
      end
    end
  end

  // Sticky status flags: a set in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_flag <= 1'b0;
      stop_flag <= 1'b0;
      reset_flag <= 1'b0;
    end
    else
    begin
      // Only bits that the read actually returned are cleared.
      if (timeout_evt && irq_mode)
      begin
        timeout_flag <= 1'b1;
      end
      else if (rd_status && prdata[`WDG_ST_TIMEOUT])
      begin
        timeout_flag <= 1'b0;
      end
      if (stop_evt)
      begin
        stop_flag <= 1'b1;
      end
      else if (rd_status && prdata[`WDG_ST_STOP])
      begin
        stop_flag <= 1'b0;
      end
      if (timeout_evt && timeout_response_option)
      begin
        reset_flag <= 1'b1;
      end
      else if (rd_status && prdata[`WDG_ST_RESET])
      begin
        reset_flag <= 1'b0;
      end
    end
  end

  // System indications, registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_out <= '0;
    end
    else
    begin
      core_out.irq <= next_irq;
      core_out.sys_reset <= next_sys_reset;
      core_out.stop_recovery <= stop_evt;
    end
  end

endmodule
`default_nettype wire

/* test/wdg_core_model.sv */
// Processor core stand-in that issues refresh pulses and holds debug and stop levels.
`default_nettype none
module wdg_core_model
  import wdg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_refresh,
  input wire logic req_debug,
  input wire logic req_stop,
  output var wdg_core_in_t core_in
);
  // Registers the requests so each one leaves just after a clock edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_in <= '0;
    else
      core_in <= '{refresh: req_refresh, debug_mode: req_debug, stop_mode: req_stop};
  end
endmodule
`default_nettype wire

/* test/wdg_downcounter_checker.sv */
// Concurrent checks on the watchdog downcounter ports.
`default_nettype none
module wdg_downcounter_checker
  import wdg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire wdg_core_in_t core_in,
  input wire wdg_core_out_t core_out
);
  // All checks sample on the system clock and pause during reset.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access phase, and one that reads the status word.
  wire logic acc = psel && penable;
  wire logic st_rd = acc && !pwrite && paddr == 12'h000;
  resp_excl_a: assert property (!(core_out.irq && core_out.sys_reset)) else $error("irq with reset");
  recov_pulse_a: assert property (core_out.stop_recovery |=> !core_out.stop_recovery) else $error("long recovery");
  // The recovery pulse leaves on the timeout edge, the registered request one edge later.
  recov_irq_a: assert property (core_out.stop_recovery |=> core_out.irq) else $error("recovery without irq");
  unmapped_err_a: assert property (acc && paddr > 12'h014 |-> pslverr) else $error("no slave error");
  mapped_ok_a: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
  debug_quiet_a: assert property (core_in.debug_mode [*3] |-> !$rose(core_out.irq)) else $error("irq in debug");
  irq_hold_a: assert property ($rose(core_out.irq) && !st_rd |=> core_out.irq) else $error("irq too short");
  reset_hold_a: assert property ($rose(core_out.sys_reset) |-> core_out.sys_reset [*3]) else $error("short reset");
  clear_drop_a: assert property (st_rd && prdata[0] |=> ##1 !core_out.irq) else $error("irq not cleared");
  cover property ($rose(core_out.irq));
  cover property ($rose(core_out.sys_reset));
  cover property (core_out.stop_recovery);
endmodule
bind wdg_downcounter wdg_downcounter_checker wdg_downcounter_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .core_in, .core_out);
`default_nettype wire

/* test/tb_wdg_downcounter.sv */
// Self-checking bench for the watchdog downcounter.
`include "wdg_consts.svh"
`default_nettype none
module tb_wdg_downcounter
  import wdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICKS = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rf = 1'b0, dbg = 1'b0, stp = 1'b0, recov_seen = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, reload, lfsr = 32'h5c7a;
  wdg_core_in_t core_in;
  wdg_core_out_t core_out;
  int fail_count = 0, checks_done = 0, n;
  always #50 pclk = ~pclk;
  wdg_core_model wdg_core_model_i (.pclk, .presetn, .req_refresh(rf), .req_debug(dbg), .req_stop(stp), .core_in);
  wdg_downcounter #(.TICK_CYCLES(TICKS)) wdg_downcounter_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .core_in, .core_out);
  // Remembers that a stop recovery pulse went by.
  always @(posedge pclk)
    if (core_out.stop_recovery === 1'b1) recov_seen <= 1'b1;
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that sees pready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task refresh();
    @(posedge pclk) rf <= 1'b1;
    @(posedge pclk) rf <= 1'b0;
  endtask
  // Waits, bounded, for one bit of the core outputs.
  task wait_out(input int b);
    n = 0;
    while (core_out[b] !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n < 400, 32'h1, "wait");
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #500000;
    fail_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `WDG_OFS_UPPER, 0); chk(rd, 32'h0, "upper");
    apb(0, `WDG_OFS_HIGH, 0); chk(rd, 32'h4, "high");
    apb(0, `WDG_OFS_LOW, 0); chk(rd, 32'h0, "low");
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'h0, "idle status");
    apb(0, 12'h018, 0); chk(err, 32'h1, "unmapped");
    $display("test reset values done");
    lfsr = next_rand(lfsr);
    reload = 32'h8 + lfsr[2:0];
    apb(1, `WDG_OFS_HIGH, 0);
    apb(1, `WDG_OFS_LOW, reload);
    refresh();
    wait_out(2);
    // Model delay and load edge, up to one tick of divider phase, reload ticks, then irq is registered and seen.
    chk(n >= (reload - 1) * TICKS + 4 && n <= reload * TICKS + 3, 32'h1, "span");
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'h9, "irq status");
    repeat (2) @(posedge pclk);
    chk(core_out.irq, 32'h0, "irq cleared");
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'h8, "flag cleared");
    apb(0, `WDG_OFS_COUNT, 0); chk(rd[23:20], 32'hf, "wrap");
    $display("test interrupt timeout done");
    @(posedge pclk) dbg <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(0, `WDG_OFS_COUNT, 0); chk(rd, reload, "debug count");
    @(posedge pclk);
    stp <= 1'b1;
    dbg <= 1'b0;
    wait_out(2);
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'hb, "stop status");
    chk(recov_seen, 32'h1, "recovery");
    stp <= 1'b0;
    $display("test debug and stop done");
    apb(1, `WDG_OFS_OPTION, 32'h2);
    apb(1, `WDG_OFS_STATUS, 0);
    wait_out(1); chk(core_out.irq, 32'h0, "no irq");
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'hc, "reset cause");
    $display("test reset response done");
    // A second reset, then the always-on option alone must start the counter.
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'h0, "off after reset");
    apb(1, `WDG_OFS_OPTION, 32'h1);
    apb(0, `WDG_OFS_STATUS, 0); chk(rd, 32'h8, "always on");
    $display("test always on done");
    results();
  end
endmodule
`default_nettype wire
